// ### design/ptdbd_top.sv
// Punch-through block decoder: mode select, differential decode, registers
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "ptdbd_regs.svh"
module ptdbd_top (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_blk_valid,
  input wire logic [63:0] i_blk_word,
  output logic o_tex_valid,
  output logic [511:0] o_texels,
  output logic [1:0] o_mode,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  // -----------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------
  logic [31:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] blk_cnt_q;
  logic [31:0] diff_cnt_q;
  logic [1:0] last_mode_q;
  logic take;
  logic wr_now;
  logic clr;
  logic stg1_vld_q;
  logic [63:0] word_q;
  ptdbd_pkg::ptdbd_mode_t mode_d;
  ptdbd_pkg::ptdbd_mode_t mode_q;
  logic [23:0] base1_d;
  logic [23:0] base2_d;
  logic [23:0] base1_q;
  logic [23:0] base2_q;
  logic [5:0] rsum;
  logic [5:0] gsum;
  logic [5:0] bsum;
  logic [4:0] red;
  logic [4:0] grn;
  logic [4:0] blu;
  logic [2:0] red_delta;
  logic [2:0] green_delta;
  logic [2:0] blue_delta;
  logic [2:0] first_half_intensity_select;
  logic [2:0] second_half_intensity_select;
  logic alpha_solid_flag;
  logic split_orientation_bit;
  logic [511:0] tex_d;
  logic [511:0] tex_q;
  logic stg2_vld_q;
  logic [1:0] mode2_q;
  logic [31:0] rdata_d;
  logic [31:0] blk_cnt_d;
  logic [31:0] diff_cnt_d;
  logic busy;

  // -----------------------------------------------------------
  // Avalon-MM slave handshake
  // -----------------------------------------------------------
  // Every access waits one cycle; data and write land when
  // waitrequest drops.
  assign take = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign wr_now = i_avs_write && ack_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // -----------------------------------------------------------
  // Control register
  // -----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ctrl_q <= `PTDBD_CTRL_RESET;
    end else if (wr_now && i_avs_address == `PTDBD_ADDR_CTRL) begin
      if (i_avs_byteenable[0]) begin
        ctrl_q[`PTDBD_CTRL_ENABLE] <= i_avs_writedata[`PTDBD_CTRL_ENABLE];
      end
    end
  end

  // Clear is a write strobe only, it never stores
  assign clr = wr_now && i_avs_address == `PTDBD_ADDR_CTRL &&
    i_avs_byteenable[0] && i_avs_writedata[`PTDBD_CTRL_CLEAR];

  // -----------------------------------------------------------
  // Read data
  // -----------------------------------------------------------
  // Busy while a block is still inside the pipeline
  assign busy = stg1_vld_q || stg2_vld_q;

  always_comb begin
    unique case (i_avs_address)
      `PTDBD_ADDR_CTRL: begin
        rdata_d = {31'h00000000, ctrl_q[`PTDBD_CTRL_ENABLE]};
      end
      `PTDBD_ADDR_STATUS: begin
        rdata_d = {29'h00000000, busy, last_mode_q};
      end
      `PTDBD_ADDR_BLK_CNT: begin
        rdata_d = blk_cnt_q;
      end
      `PTDBD_ADDR_DIFF_CNT: begin
        rdata_d = diff_cnt_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Captured on the waiting cycle, so it stands while waitrequest
  // is low.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rdata_q <= 32'h00000000;
    end else if (take && i_avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_avs_readdata = rdata_q;

  // -----------------------------------------------------------
  // Block statistics
  // -----------------------------------------------------------
  // A block arriving with a clear counts after the clear.
  always_comb begin
    blk_cnt_d = clr ? 32'h00000000 : blk_cnt_q;
    if (stg1_vld_q) begin
      blk_cnt_d = blk_cnt_d + 32'h00000001;
    end
  end

  always_comb begin
    diff_cnt_d = clr ? 32'h00000000 : diff_cnt_q;
    if (stg1_vld_q && mode_q == ptdbd_pkg::PTDBD_MODE_DIFF) begin
      diff_cnt_d = diff_cnt_d + 32'h00000001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      blk_cnt_q <= 32'h00000000;
    end else begin
      blk_cnt_q <= blk_cnt_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      diff_cnt_q <= 32'h00000000;
    end else begin
      diff_cnt_q <= diff_cnt_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      last_mode_q <= 2'b00;
    end else if (stg1_vld_q) begin
      last_mode_q <= mode_q;
    end
  end

  // -----------------------------------------------------------
  // Field extraction
  // -----------------------------------------------------------
  assign red = i_blk_word[`PTDBD_RED_HI:`PTDBD_RED_LO];
  assign grn = i_blk_word[`PTDBD_GRN_HI:`PTDBD_GRN_LO];
  assign blu = i_blk_word[`PTDBD_BLU_HI:`PTDBD_BLU_LO];
  assign red_delta = i_blk_word[`PTDBD_RDELTA_HI:`PTDBD_RDELTA_LO];
  assign green_delta = i_blk_word[`PTDBD_GDELTA_HI:`PTDBD_GDELTA_LO];
  assign blue_delta = i_blk_word[`PTDBD_BDELTA_HI:`PTDBD_BDELTA_LO];

  // Six-bit sums: bit 5 set means outside 0..31
  assign rsum = {1'b0, red} + {{3{red_delta[2]}}, red_delta};
  assign gsum = {1'b0, grn} + {{3{green_delta[2]}}, green_delta};
  assign bsum = {1'b0, blu} + {{3{blue_delta[2]}}, blue_delta};

  // -----------------------------------------------------------
  // Mode selection
  // -----------------------------------------------------------
  always_comb begin
    if (rsum[5]) begin
      mode_d = ptdbd_pkg::PTDBD_MODE_T;
    end else if (gsum[5]) begin
      mode_d = ptdbd_pkg::PTDBD_MODE_H;
    end else if (bsum[5]) begin
      mode_d = ptdbd_pkg::PTDBD_MODE_PLANAR;
    end else begin
      mode_d = ptdbd_pkg::PTDBD_MODE_DIFF;
    end
  end

  // -----------------------------------------------------------
  // Base colours
  // -----------------------------------------------------------
  // Widen by copying the top three bits below the field.
  // Low five bits of the sums are exact in differential mode.
  // Red in the top byte, blue in the low byte, the texel bus order without its alpha byte.
  assign base1_d = {red, red[4:2], grn, grn[4:2], blu, blu[4:2]};
  assign base2_d = {rsum[4:0], rsum[4:2], gsum[4:0], gsum[4:2],
    bsum[4:0], bsum[4:2]};

  // -----------------------------------------------------------
  // Stage 1: accept block
  // -----------------------------------------------------------
  // Blocks offered while disabled are dropped.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      stg1_vld_q <= 1'b0;
    end else begin
      stg1_vld_q <= i_blk_valid && ctrl_q[`PTDBD_CTRL_ENABLE];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      word_q <= 64'h0000000000000000;
      mode_q <= ptdbd_pkg::PTDBD_MODE_DIFF;
      base1_q <= 24'h000000;
      base2_q <= 24'h000000;
    end else if (i_blk_valid && ctrl_q[`PTDBD_CTRL_ENABLE]) begin
      word_q <= i_blk_word;
      mode_q <= mode_d;
      base1_q <= base1_d;
      base2_q <= base2_d;
    end
  end

  // -----------------------------------------------------------
  // Per-block controls
  // -----------------------------------------------------------
  assign first_half_intensity_select = word_q[`PTDBD_SEL1_HI:`PTDBD_SEL1_LO];
  assign second_half_intensity_select = word_q[`PTDBD_SEL2_HI:`PTDBD_SEL2_LO];
  assign alpha_solid_flag = word_q[`PTDBD_SOLID_BIT];
  assign split_orientation_bit = word_q[`PTDBD_SPLIT_BIT];

  // -----------------------------------------------------------
  // Texel units
  // -----------------------------------------------------------
  // Texels a..p run down each column; texel t sits in column
  // t/4, row t%4.
  for (genvar t = 0; t < 16; t++) begin : g_tex
    logic second;
    logic [2:0] sel;
    ptdbd_tex_if tif ();

    // Column split when clear, row split when set
    assign second = split_orientation_bit ? ((t % 4) >= 2) : (t >= 8);
    assign sel = second ? second_half_intensity_select
      : first_half_intensity_select;
    assign tif.base = second ? base2_q : base1_q;
    assign tif.big = ptdbd_pkg::ptdbd_big(sel);
    // Small entries of the transparent set are zero
    assign tif.small_mag = alpha_solid_flag ? ptdbd_pkg::ptdbd_small(sel)
      : 8'h00;
    assign tif.solid = alpha_solid_flag;
    // Same bit pair for a texel whatever the split
    assign tif.idx = {word_q[`PTDBD_IDX_MSB_BASE + t],
      word_q[`PTDBD_IDX_LSB_BASE + t]};

    ptdbd_texel u_texel (
      .io(tif.calc)
    );

    // Only differential blocks are reconstructed here
    assign tex_d[t*32 +: 32] = mode_q == ptdbd_pkg::PTDBD_MODE_DIFF
      ? tif.rgba : 32'h00000000;
  end

  // -----------------------------------------------------------
  // Stage 2: output texels
  // -----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      stg2_vld_q <= 1'b0;
    end else begin
      stg2_vld_q <= stg1_vld_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      tex_q <= '0;
      mode2_q <= 2'b00;
    end else if (stg1_vld_q) begin
      tex_q <= tex_d;
      mode2_q <= mode_q;
    end
  end

  assign o_tex_valid = stg2_vld_q;
  assign o_texels = tex_q;
  assign o_mode = mode2_q;

endmodule : ptdbd_top

// ### design/ptdbd_regs.svh
// Register offsets, block field positions, reset values and timing counts
`ifndef PTDBD_REGS_SVH
`define PTDBD_REGS_SVH
// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define PTDBD_ADDR_CTRL 4'h0
`define PTDBD_ADDR_STATUS 4'h4
`define PTDBD_ADDR_BLK_CNT 4'h8
`define PTDBD_ADDR_DIFF_CNT 4'hc
`define PTDBD_CTRL_ENABLE 0
`define PTDBD_CTRL_CLEAR 1
`define PTDBD_CTRL_RESET 32'h00000001
`define PTDBD_STAT_BUSY 2
// -------------------------------------------------------------
// Block word fields
// -------------------------------------------------------------
`define PTDBD_RED_HI 63
`define PTDBD_RED_LO 59
`define PTDBD_RDELTA_HI 58
`define PTDBD_RDELTA_LO 56
`define PTDBD_GRN_HI 55
`define PTDBD_GRN_LO 51
`define PTDBD_GDELTA_HI 50
`define PTDBD_GDELTA_LO 48
`define PTDBD_BLU_HI 47
`define PTDBD_BLU_LO 43
`define PTDBD_BDELTA_HI 42
`define PTDBD_BDELTA_LO 40
`define PTDBD_SEL1_HI 39
`define PTDBD_SEL1_LO 37
`define PTDBD_SEL2_HI 36
`define PTDBD_SEL2_LO 34
`define PTDBD_SOLID_BIT 33
`define PTDBD_SPLIT_BIT 32
`define PTDBD_IDX_MSB_BASE 16
`define PTDBD_IDX_LSB_BASE 0
// -------------------------------------------------------------
// Timing
// -------------------------------------------------------------
`define PTDBD_LATENCY 2
`endif

// ### design/ptdbd_pkg.sv
// Types shared by the decoder modules
package ptdbd_pkg;
  typedef enum logic [1:0] {
    PTDBD_MODE_DIFF = 2'b00,
    PTDBD_MODE_T = 2'b01,
    PTDBD_MODE_H = 2'b10,
    PTDBD_MODE_PLANAR = 2'b11
  } ptdbd_mode_t;
  typedef logic [7:0] ptdbd_mag_t;
  // Large magnitude of each modifier quadruple
  function automatic ptdbd_mag_t ptdbd_big(input logic [2:0] sel);
    unique case (sel)
      3'h0: ptdbd_big = 8'h08;
      3'h1: ptdbd_big = 8'h11;
      3'h2: ptdbd_big = 8'h1d;
      3'h3: ptdbd_big = 8'h2a;
      3'h4: ptdbd_big = 8'h3c;
      3'h5: ptdbd_big = 8'h50;
      3'h6: ptdbd_big = 8'h6a;
      3'h7: ptdbd_big = 8'hb7;
    endcase
  endfunction : ptdbd_big
  // Small magnitude of each modifier quadruple
  function automatic ptdbd_mag_t ptdbd_small(input logic [2:0] sel);
    unique case (sel)
      3'h0: ptdbd_small = 8'h02;
      3'h1: ptdbd_small = 8'h05;
      3'h2: ptdbd_small = 8'h09;
      3'h3: ptdbd_small = 8'h0d;
      3'h4: ptdbd_small = 8'h12;
      3'h5: ptdbd_small = 8'h18;
      3'h6: ptdbd_small = 8'h21;
      3'h7: ptdbd_small = 8'h2f;
    endcase
  endfunction : ptdbd_small
endpackage : ptdbd_pkg

// ### design/ptdbd_tex_if.sv
// Per-texel carrier between the block decoder and its texel units
`timescale 1ns/100ps
interface ptdbd_tex_if;
  logic [23:0] base;
  logic [7:0] big;
  logic [7:0] small_mag;
  logic [1:0] idx;
  logic solid;
  logic [31:0] rgba;
  modport drv (output base, output big, output small_mag, output idx, output solid, input rgba);
  modport calc (input base, input big, input small_mag, input idx, input solid, output rgba);
endinterface : ptdbd_tex_if

// ### design/ptdbd_texel.sv
// One texel: modifier pick, add, clamp and punch-through alpha
`timescale 1ns/100ps
module ptdbd_texel (
  ptdbd_tex_if.calc io
);
  logic signed [9:0] mod;
  logic punch;
  // -----------------------------------------------------------
  // Modifier from index
  // -----------------------------------------------------------
  always_comb begin
    unique case (io.idx)
      2'b11: mod = -$signed({2'b00, io.big});
      2'b01: mod = $signed({2'b00, io.big});
      2'b10: mod = io.solid ? -$signed({2'b00, io.small_mag}) : 10'sh000;
      2'b00: mod = io.solid ? $signed({2'b00, io.small_mag}) : 10'sh000;
    endcase
  end
  assign punch = !io.solid && io.idx == 2'b10;
  // -----------------------------------------------------------
  // Channel add and clamp
  // -----------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic signed [9:0] sum;
    assign sum = $signed({2'b00, io.base[c*8 +: 8]}) + mod;
    assign io.rgba[8 + c*8 +: 8] = punch ? 8'h00 :
      sum < 10'sh000 ? 8'h00 : sum > 10'sh0ff ? 8'hff : sum[7:0];
  end
  assign io.rgba[7:0] = punch ? 8'h00 : 8'hff;
endmodule : ptdbd_texel

// ### dv/ptdbd_fetch_model.sv
// Texture-fetch side model: presents block words and collects results
`timescale 1ns/100ps
module ptdbd_fetch_model (
  input wire logic i_clk,
  output logic o_blk_valid,
  output logic [63:0] o_blk_word,
  input wire logic i_tex_valid,
  input wire logic [511:0] i_texels,
  input wire logic [1:0] i_mode
);
  logic [511:0] got_t[$];
  logic [1:0] got_m[$];
  initial begin
    o_blk_valid = 1'b0;
    o_blk_word = 64'h0;
  end
  // Results stand one cycle, so every strobe is taken at its own edge
  always @(posedge i_clk) begin
    if (i_tex_valid === 1'b1) begin
      got_t.push_back(i_texels);
      got_m.push_back(i_mode);
    end
  end
  // Words go out back to back; the idle word is the last word inverted, not held
  task automatic send(input logic [63:0] w[$]);
    foreach (w[k]) begin
      @(posedge i_clk);
      o_blk_valid <= 1'b1;
      o_blk_word <= w[k];
    end
    @(posedge i_clk);
    o_blk_valid <= 1'b0;
    o_blk_word <= ~o_blk_word;
  endtask : send
endmodule : ptdbd_fetch_model

// ### dv/ptdbd_top_asserts.sv
// Port-level assertions for the block decoder
`timescale 1ns/100ps
module ptdbd_top_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_blk_valid,
  input wire logic [63:0] i_blk_word,
  input wire logic o_tex_valid,
  input wire logic [511:0] o_texels,
  input wire logic [1:0] o_mode
);
  logic [63:0] w1_q;
  logic [63:0] w2_q;
  logic [5:0] rs;
  logic [5:0] gs;
  logic [5:0] bs;
  // Word of the block whose result is on the outputs now
  always_ff @(posedge i_clk_sys) begin
    w1_q <= i_blk_word;
    w2_q <= w1_q;
  end
  assign rs = {1'b0, w2_q[63:59]} + {{3{w2_q[58]}}, w2_q[58:56]};
  assign gs = {1'b0, w2_q[55:51]} + {{3{w2_q[50]}}, w2_q[50:48]};
  assign bs = {1'b0, w2_q[47:43]} + {{3{w2_q[42]}}, w2_q[42:40]};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence res_s;
    o_tex_valid;
  endsequence
  sequence diff_s;
    o_tex_valid && !rs[5] && !gs[5] && !bs[5];
  endsequence
  out_lat_a:
    assert property (o_tex_valid |-> $past(i_blk_valid, 2)) else $error("result without block");
  res_hold_a:
    assert property (!o_tex_valid |-> $stable(o_texels)) else $error("texels changed idle");
  mode_t_a:
    assert property (res_s ##0 rs[5] |-> o_mode == 2'b01) else $error("red overflow not T");
  mode_h_a:
    assert property (res_s ##0 (!rs[5] && gs[5]) |-> o_mode == 2'b10) else $error("not H");
  mode_pl_a:
    assert property (res_s ##0 (!rs[5] && !gs[5] && bs[5]) |-> o_mode == 2'b11)
      else $error("not planar");
  mode_diff_a:
    assert property (diff_s |-> o_mode == 2'b00) else $error("not differential");
  solid_alpha_a:
    assert property (diff_s ##0 w2_q[33] |-> o_texels[7:0] == 8'hff && o_texels[487:480] == 8'hff)
      else $error("solid alpha not full");
  punch_d_a:
    assert property (diff_s ##0 (!w2_q[33] && w2_q[19] && !w2_q[3]) |-> o_texels[127:96] == 32'h0)
      else $error("punched texel not zero");
endmodule : ptdbd_top_asserts
bind ptdbd_top ptdbd_top_asserts chk_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .i_blk_valid(i_blk_valid), .i_blk_word(i_blk_word), .o_tex_valid(o_tex_valid),
  .o_texels(o_texels), .o_mode(o_mode));

// ### dv/tb_ptdbd_top.sv
// Self-checking bench for the block decoder
`timescale 1ns/100ps
module tb_ptdbd_top;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic blk_valid;
  logic [63:0] blk_word;
  logic o_tex_valid;
  logic [511:0] o_texels;
  logic [1:0] o_mode;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  int err_count = 0;
  int total_checks = 0;
  int bigs[8] = '{8, 17, 29, 42, 60, 80, 106, 183};
  int smalls[8] = '{2, 5, 9, 13, 18, 24, 33, 47};
  always #2 i_clk_sys = ~i_clk_sys;
  ptdbd_top dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_blk_valid(blk_valid),
    .i_blk_word(blk_word), .o_tex_valid(o_tex_valid), .o_texels(o_texels), .o_mode(o_mode),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
  ptdbd_fetch_model fm_u (.i_clk(i_clk_sys), .o_blk_valid(blk_valid), .o_blk_word(blk_word),
    .i_tex_valid(o_tex_valid), .i_texels(o_texels), .i_mode(o_mode));
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Expected texel t of a differential block
  function automatic logic [31:0] ref_texel(input logic [63:0] w, input int t);
    int sub;
    int m;
    int v;
    logic [1:0] ix;
    logic [2:0] sel;
    logic [4:0] c5;
    logic [31:0] r;
    sub = w[32] ? int'(t % 4 >= 2) : int'(t / 4 >= 2);
    ix = {w[16 + t], w[t]};
    sel = sub ? w[36:34] : w[39:37];
    m = ix[0] ? bigs[sel] : (w[33] ? smalls[sel] : 0);
    if (ix[1]) m = -m;
    r = 32'hff;
    for (int ch = 0; ch < 3; ch++) begin
      c5 = w[63 - 8 * ch -: 5] + (sub ? {{2{w[58 - 8 * ch]}}, w[58 - 8 * ch -: 3]} : 5'h0);
      v = int'({c5, c5[4:2]}) + m;
      v = v < 0 ? 0 : (v > 255 ? 255 : v);
      r[31 - 8 * ch -: 8] = v[7:0];
    end
    return (!w[33] && ix == 2'b10) ? 32'h0 : r;
  endfunction : ref_texel
  task automatic wait_res(input int n);
    int c;
    c = 0;
    while (fm_u.got_t.size() < n && c < 100) begin
      @(posedge i_clk_sys);
      c++;
    end
    if (fm_u.got_t.size() < n) begin
      err_count++;
      $display("wrong value result count expected %0d seen %0d", n, fm_u.got_t.size());
      close_out();
    end
  endtask : wait_res
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= wd;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("wrong value waitrequest expected 0 seen %b", o_avs_waitrequest);
      close_out();
    end
  endtask : avs
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic diff_blocks;
    logic [63:0] ws[$];
    int b;
    b = fm_u.got_t.size();
    for (int k = 0; k < 16; k++) begin
      ws.push_back({5'd31, 3'd0, 5'd0, 3'd3, 5'd16, 3'd4, k[2:0], k[2:0] ^ 3'h5, k[3], k[0],
                    16'h3c3c, 16'ha5a5 ^ k[15:0]});
    end
    fm_u.send(ws);
    wait_res(b + 16);
    foreach (ws[k]) begin
      chk("mode", 32'h0, {30'h0, fm_u.got_m[b + k]});
      for (int t = 0; t < 16; t++) begin
        chk("texel", ref_texel(ws[k], t), fm_u.got_t[b + k][32 * t +: 32]);
      end
    end
  endtask : diff_blocks
  task automatic mode_blocks;
    logic [63:0] ws[$];
    logic [1:0] em[5] = '{2'b01, 2'b01, 2'b10, 2'b11, 2'b11};
    int b;
    b = fm_u.got_t.size();
    ws = '{{5'd31, 3'd3, 5'd0, 3'd0, 5'd0, 3'd0, 40'h0},
           {5'd0, 3'd4, 5'd0, 3'd0, 5'd0, 3'd0, 40'h0},
           {5'd0, 3'd0, 5'd31, 3'd1, 5'd0, 3'd0, 40'h0},
           {5'd0, 3'd0, 5'd0, 3'd0, 5'd0, 3'd4, 40'h0},
           {5'd0, 3'd0, 5'd0, 3'd0, 5'd31, 3'd1, 40'h0}};
    fm_u.send(ws);
    wait_res(b + 5);
    foreach (ws[k]) begin
      chk("mode", {30'h0, em[k]}, {30'h0, fm_u.got_m[b + k]});
      chk("texels zero", 32'h0, {31'h0, |fm_u.got_t[b + k]});
    end
  endtask : mode_blocks
  task automatic reg_access;
    logic [31:0] rd;
    int n;
    avs(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    i_avs_byteenable <= 4'he;
    avs(1'b1, 4'h0, 32'h0, rd);
    i_avs_byteenable <= 4'hf;
    avs(1'b0, 4'h0, 32'h0, rd);
    chk("masked ctrl", 32'h1, rd);
    avs(1'b0, 4'h8, 32'h0, rd);
    chk("block count", 32'd21, rd);
    avs(1'b0, 4'hc, 32'h0, rd);
    chk("diff count", 32'd16, rd);
    avs(1'b0, 4'h4, 32'h0, rd);
    chk("status", 32'h3, rd);
    avs(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    avs(1'b1, 4'h0, 32'h0, rd);
    n = fm_u.got_t.size();
    fm_u.send('{64'h0});
    repeat (6) @(posedge i_clk_sys);
    chk("dropped", n, fm_u.got_t.size());
    avs(1'b1, 4'h0, 32'h3, rd);
    avs(1'b0, 4'h8, 32'h0, rd);
    chk("cleared count", 32'h0, rd);
    avs(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    fm_u.send('{64'h0});
    wait_res(n + 1);
    avs(1'b0, 4'h8, 32'h0, rd);
    chk("block count", 32'h1, rd);
  endtask : reg_access
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    diff_blocks();
    mode_blocks();
    reg_access();
    close_out();
  end
endmodule : tb_ptdbd_top
